/* hdl/sctl_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - Write only while select and strobe both low; end-of-overlap data stored.
// - Host keeps strobe high in reads; select and drive low return data.
// - Drive control may be either level in a write; high keeps outputs off.
// - Host gives a valid index no later than the select transition.
// - Read data valid within 90 ns; reads spaced at least 90 ns.
// - Host holds select low 60 ns before write end; writes 90 ns apart.
// - Host holds select and strobe overlap at least 55 ns.
module sctl_ctrl
    import sctl_pkg::*;
(
    input  wire logic              clk_in,          // 10 MHz system clock.
    input  wire logic              reset_n_in,      // Asynchronous reset, active low.
    input  wire logic              ce_in,           // Clock enable; low freezes all state but the two reset release stages.
    input  wire sctl_req_t         req_in,          // Request: write flag, index, data.
    input  wire logic              req_valid_in,    // Request offered.
    output logic                   req_ready_out,   // Request taken when valid and ready.
    output logic [DATA_W-1:0]      rd_data_out,     // Read data.
    output logic                   rd_valid_out,    // One-cycle pulse with read data.
    output logic                   select_n_out,    // Device select, active low.
    output logic                   strobe_n_out,    // Write strobe, active low.
    output logic                   drive_n_out,     // Output drive control, active low.
    output logic [INDEX_W-1:0]     word_index_out,  // Word index.
    input  wire logic [DATA_W-1:0] data_lines_in,   // Data lines as seen on the wire.
    output logic [DATA_W-1:0]      data_lines_out,  // Data the host drives.
    output logic                   data_lines_oe_out // High while the host drives the lines.
);

    // Every access passes through RECOVER, so requests are never back to back.
    typedef enum logic [2:0] {
        ST_IDLE, ST_WSETUP, ST_WPULSE, ST_WHOLD, ST_RACCESS, ST_RECOVER
    } sctl_state_t;

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta;
    logic rst_n;

    // Two stages so the release never lands close to a clock edge.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==========================================================
    // State and registered pins
    // ==========================================================
    // Pins travel as one struct so a single flop group launches them together.
    sctl_state_t      state;
    sctl_state_t      next_state;
    sctl_pins_t       pins;
    sctl_pins_t       next_pins;
    sctl_req_t        held;
    logic             oe;
    logic             next_oe;
    logic             ready;
    logic             next_ready;
    logic             tmr_done;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_count;

    // Requests are taken only from IDLE; the timer alone ends each phase.
    // Phase end must not depend on the load it causes, or the decode would loop on itself.
    wire take     = ready && req_valid_in;
    wire phase_up = tmr_done;
    wire read_end = (state == ST_RACCESS) && phase_up;

    // One shared down counter times every phase, since no two phases overlap.
    sctl_timer u_timer (
        .clk_in   (clk_in),
        .rst_n_in (rst_n),
        .ce_in    (ce_in),
        .load_in  (tmr_load),
        .count_in (tmr_count),
        .done_out (tmr_done)
    );

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Each phase lasts a whole number of 100 ns cycles, so every least time is met by one cycle.
    // The timer is loaded only where a phase ends, so no phase restarts part way.
    always_comb begin
        next_state = state;
        next_pins  = pins;
        next_oe    = oe;
        next_ready = 1'b0;
        tmr_load   = 1'b0;
        tmr_count  = '0;
        case (state)
            ST_IDLE: begin
                next_ready = 1'b1;
                if (take) begin
                    next_ready            = 1'b0;
                    next_pins.word_index  = req_in.index;
                    tmr_load              = 1'b1;
                    if (req_in.write) begin
                        // Index settles with select still high; strobe stays high.
                        next_pins.drive_n = 1'b1;
                        next_oe           = 1'b1;
                        tmr_count         = CNT_W'(SETUP_CYC);
                        next_state        = ST_WSETUP;
                    end else begin
                        // Index and select change together, strobe held high.
                        next_pins.select_n = 1'b0;
                        next_pins.strobe_n = 1'b1;
                        next_pins.drive_n  = 1'b0;
                        tmr_count          = CNT_W'(ACCESS_CYC);
                        next_state         = ST_RACCESS;
                    end
                end
            end
            ST_WSETUP: if (phase_up) begin
                // Select and strobe fall together, so the memory never drives.
                next_pins.select_n = 1'b0;
                next_pins.strobe_n = 1'b0;
                tmr_load           = 1'b1;
                tmr_count          = CNT_W'(PULSE_CYC);
                next_state         = ST_WPULSE;
            end
            ST_WPULSE: if (phase_up) begin
                // Both rise together; the data is held one more cycle past the end.
                next_pins.select_n = 1'b1;
                next_pins.strobe_n = 1'b1;
                tmr_load           = 1'b1;
                tmr_count          = CNT_W'(1);
                next_state         = ST_WHOLD;
            end
            ST_WHOLD: if (phase_up) begin
                // The host lets go of the data lines a cycle after the strobe has risen.
                next_oe    = 1'b0;
                tmr_load   = 1'b1;
                tmr_count  = CNT_W'(RECOV_CYC);
                next_state = ST_RECOVER;
            end
            ST_RACCESS: if (phase_up) begin
                // Deselect ends the read and lets the memory idle in standby.
                next_pins.select_n = 1'b1;
                next_pins.drive_n  = 1'b1;
                tmr_load           = 1'b1;
                tmr_count          = CNT_W'(RECOV_CYC);
                next_state         = ST_RECOVER;
            end
            ST_RECOVER: if (phase_up) begin
                // The memory's driver must be gone before the host drives again.
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
                next_pins  = PINS_IDLE;
                next_oe    = 1'b0;
            end
        endcase
    end

    // State, pins and ready move together, so every pin edge lands on a clock edge.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            pins  <= PINS_IDLE;
            oe    <= 1'b0;
            ready <= 1'b0;
        end else if (ce_in) begin
            state <= next_state;
            pins  <= next_pins;
            oe    <= next_oe;
            ready <= next_ready;
        end
    end

    // ==========================================================
    // Write data and read capture
    // ==========================================================
    // Capturing at the end of the access phase samples after the full 90 ns access time.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            held         <= '0;
            rd_data_out  <= '0;
            rd_valid_out <= 1'b0;
        end else if (ce_in) begin
            if (take) begin
                held <= req_in;
            end
            rd_valid_out <= read_end;
            if (read_end) begin
                rd_data_out <= data_lines_in;
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Every pin is a flop output, so no decode glitch ever reaches the memory.
    assign req_ready_out     = ready;
    assign select_n_out      = pins.select_n;
    assign strobe_n_out      = pins.strobe_n;
    assign drive_n_out       = pins.drive_n;
    assign word_index_out    = pins.word_index;
    assign data_lines_out    = held.data;
    assign data_lines_oe_out = oe;

endmodule

/* hdl/sctl_pkg.sv */
package sctl_pkg;

    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int INDEX_W = 11;
    localparam int DATA_W  = 8;
    localparam int WORDS   = 2048;

    // ==========================================================
    // Timing, fastest grade
    // ==========================================================
    localparam int CLK_PERIOD_NS            = 100;
    localparam int READ_CYCLE_MIN_NS        = 90;
    localparam int INDEX_ACCESS_MAX_NS      = 90;
    localparam int OUT_ENABLE_MAX_NS        = 35;
    localparam int SELECT_TO_WRITE_END_MIN_NS = 60;
    localparam int WRITE_PULSE_MIN_NS       = 55;
    localparam int WRITE_CYCLE_MIN_NS       = 90;
    localparam int INDEX_SETUP_MIN_NS       = 20;
    localparam int DATA_SETUP_MIN_NS        = 30;
    localparam int STROBE_TO_FLOAT_MAX_NS   = 25;
    localparam int DESELECT_FLOAT_MAX_NS    = 40;

    // Least times round up, and every phase lasts at least one cycle.
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC  = cyc_up(INDEX_SETUP_MIN_NS);
    localparam int PULSE_CYC  = cyc_up(WRITE_PULSE_MIN_NS > SELECT_TO_WRITE_END_MIN_NS ?
                                       WRITE_PULSE_MIN_NS : SELECT_TO_WRITE_END_MIN_NS);
    localparam int ACCESS_CYC = cyc_up(INDEX_ACCESS_MAX_NS);
    localparam int RECOV_CYC  = cyc_up(DESELECT_FLOAT_MAX_NS);
    localparam int CNT_W      = 4;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic               write;
        logic [INDEX_W-1:0] index;
        logic [DATA_W-1:0]  data;
    } sctl_req_t;

    typedef struct packed {
        logic               select_n;
        logic               strobe_n;
        logic               drive_n;
        logic [INDEX_W-1:0] word_index;
    } sctl_pins_t;

    localparam sctl_pins_t PINS_IDLE = '{select_n: 1'b1, strobe_n: 1'b1,
                                         drive_n: 1'b1, word_index: '0};

endpackage

/* hdl/sctl_timer.sv */
`timescale 1ns/1ps
module sctl_timer
    import sctl_pkg::*;
(
    input  wire logic             clk_in,    // System clock.
    input  wire logic             rst_n_in,  // Synchronised reset, active low.
    input  wire logic             ce_in,     // Clock enable.
    input  wire logic             load_in,   // Load a new count.
    input  wire logic [CNT_W-1:0] count_in,  // Cycles to wait.
    output logic                  done_out   // High when one cycle or none is left.
);

    logic [CNT_W-1:0] remain;

    // ==========================================================
    // Down counter
    // ==========================================================
    // The phase ends in the cycle the counter reads one, so a load of N spans N cycles.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remain <= '0;
        end else if (ce_in) begin
            if (load_in) begin
                remain <= count_in;
            end else if (remain != '0) begin
                remain <= remain - 1'b1;
            end
        end
    end

    assign done_out = (remain <= CNT_W'(1));

endmodule

/* tb/async_sram_2k_by_8_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h seen %h", n, e, g); end end
module async_sram_2k_by_8_tb_top
    import sctl_pkg::*;
;
    logic               clk_in, reset_n_in, ce_in, req_valid_in, req_ready_out, rd_valid_out;
    logic               select_n_out, strobe_n_out, drive_n_out, data_lines_oe_out, mem_oe;
    sctl_req_t          req_in;
    logic [DATA_W-1:0]  rd_data_out, data_lines_out, mem_q, wire_lvl;
    logic [INDEX_W-1:0] word_index_out, idx;
    logic [DATA_W-1:0]  shadow [WORDS];
    logic [WORDS-1:0]   known;
    int                 errors, total_checks, seed_ret;

    // An undriven wire shows a pattern that flips each half cycle, never the last value.
    assign wire_lvl = mem_oe ? mem_q : data_lines_oe_out ? data_lines_out :
                      (8'h5A ^ {DATA_W{clk_in}});

    sctl_ctrl sctl_ctrl_inst (.clk_in, .reset_n_in, .ce_in, .req_in, .req_valid_in,
        .req_ready_out, .rd_data_out, .rd_valid_out, .select_n_out, .strobe_n_out,
        .drive_n_out, .word_index_out, .data_lines_in(wire_lvl), .data_lines_out,
        .data_lines_oe_out);
    sctl_mem_model #(.ACCESS_NS(80)) sctl_mem_model_inst (.select_n_in(select_n_out),
        .strobe_n_in(strobe_n_out), .drive_n_in(drive_n_out), .word_index_in(word_index_out),
        .data_lines_in(wire_lvl), .mem_data_out(mem_q), .mem_oe_out(mem_oe));

    // ==========================================================
    // Tasks
    // ==========================================================
    function automatic logic [DATA_W-1:0] exp_of(input logic [INDEX_W-1:0] i);
        return shadow[i];
    endfunction

    // Valid stays up between calls, so no edge sees it assigned twice.
    task automatic access(input logic w, input logic [INDEX_W-1:0] i,
                          input logic [DATA_W-1:0] d);
        int n;
        req_valid_in <= 1'b1;
        req_in       <= '{write: w, index: i, data: d};
        n = 0;
        do begin @(posedge clk_in); n++; end while (req_ready_out !== 1'b1 && n < 20);
        `CHK("req_ready", 1'b1, req_ready_out)
        if (w) begin
            shadow[i] = d;
            known[i]  = 1'b1;
        end else begin
            n = 0;
            do begin @(posedge clk_in); n++; end while (rd_valid_out !== 1'b1 && n < 6);
            `CHK("rd_data", exp_of(i), rd_data_out)
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        clk_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
    end

    // Runs take some 400 cycles; this limit leaves ample margin.
    initial begin
        #(20000 * CLK_PERIOD_NS);
        errors++;
        test_done();
    end

    initial begin
        reset_n_in = 1'b0; ce_in = 1'b1; req_valid_in = 1'b0; req_in = '0; known = '0;
        seed_ret = $urandom(61560);
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        // Boundary words, back to back.
        access(1'b1, 11'h000, 8'hA5);
        access(1'b1, 11'h7FF, 8'h3C);
        access(1'b0, 11'h000, 8'h00);
        access(1'b0, 11'h7FF, 8'h00);
        $display("test corners done");
        // Clock enable low: an offered request must wait, not be taken.
        ce_in  <= 1'b0;
        req_in <= '{write: 1'b1, index: 11'h001, data: 8'h96};
        repeat (3) @(posedge clk_in);
        `CHK("frozen_ready", 1'b1, req_ready_out)
        `CHK("frozen_select", 1'b1, select_n_out)
        ce_in <= 1'b1;
        access(1'b1, 11'h001, 8'h96);
        access(1'b0, 11'h001, 8'h00);
        $display("test enable done");
        // Random traffic over a small window so reads hit earlier writes.
        for (int k = 0; k < 80; k++) begin
            idx = INDEX_W'($urandom_range(15, 0)) ^ (k[0] ? 11'h7F0 : 11'h000);
            access(known[idx] ? 1'($urandom_range(1, 0)) : 1'b1, idx, 8'($urandom));
        end
        $display("test random done");
        // Reset in mid-run; the memory must keep its contents.
        // Let the last transfer finish, so reset never cuts a write pulse short.
        req_valid_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        `CHK("idle_ready", 1'b1, req_ready_out)
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        access(1'b0, 11'h000, 8'h00);
        access(1'b0, 11'h7FF, 8'h00);
        $display("test reset done");
        test_done();
    end
endmodule

bind sctl_ctrl sctl_ctrl_props sctl_ctrl_props_inst (.clk_in, .reset_n_in, .ce_in, .req_in,
    .req_valid_in, .req_ready_out, .rd_data_out, .rd_valid_out, .select_n_out,
    .strobe_n_out, .drive_n_out, .word_index_out, .data_lines_in, .data_lines_out,
    .data_lines_oe_out);

/* tb/sctl_ctrl_props.sv */
`timescale 1ns/1ps
module sctl_ctrl_props
    import sctl_pkg::*;
(
    input wire logic               clk_in,            // Clock.
    input wire logic               reset_n_in,        // Reset, active low.
    input wire logic               ce_in,             // Clock enable.
    input wire sctl_req_t          req_in,            // Request.
    input wire logic               req_valid_in,      // Request offered.
    input wire logic               req_ready_out,     // Ready for a request.
    input wire logic [DATA_W-1:0]  rd_data_out,       // Read data.
    input wire logic               rd_valid_out,      // Read data pulse.
    input wire logic               select_n_out,      // Device select.
    input wire logic               strobe_n_out,      // Write strobe.
    input wire logic               drive_n_out,       // Output drive.
    input wire logic [INDEX_W-1:0] word_index_out,    // Word index.
    input wire logic [DATA_W-1:0]  data_lines_in,     // Resolved wire.
    input wire logic [DATA_W-1:0]  data_lines_out,    // Host data.
    input wire logic               data_lines_oe_out  // Host drive enable.
);
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    wire take = req_valid_in && req_ready_out && ce_in;
    wire rd   = take && !req_in.write;
    wire wr   = take && req_in.write;

    a_take_busy: assert property (take |=> !req_ready_out)
        else $error("Ready stayed high after a take.");
    a_read_pins: assert property (rd |=>
        !select_n_out && !drive_n_out && strobe_n_out)
        else $error("Read pins wrong after a take.");
    a_read_answer: assert property (rd |-> ##2 rd_valid_out ##1 !rd_valid_out)
        else $error("Read pulse not at its cycle.");
    a_read_back: assert property (rd |-> ##[3:5] req_ready_out)
        else $error("Ready late after a read.");
    a_write_shape: assert property (wr |=>
        (select_n_out && strobe_n_out) ##1 (!select_n_out && !strobe_n_out) ##1
        (select_n_out && strobe_n_out))
        else $error("Write pulse shape wrong.");
    a_write_back: assert property (wr |-> ##[4:7] req_ready_out)
        else $error("Ready late after a write.");
    a_no_clash: assert property (data_lines_oe_out |-> drive_n_out)
        else $error("Host drives while the memory may drive.");
    a_write_data: assert property (!strobe_n_out |->
        !select_n_out && data_lines_oe_out && $past(data_lines_oe_out))
        else $error("Write data not set up.");
    a_index_hold: assert property (!select_n_out |=> $stable(word_index_out))
        else $error("Index moved while selected.");
    a_read_sample: assert property ($rose(rd_valid_out) |->
        rd_data_out == $past(data_lines_in))
        else $error("Read data not taken from the wire.");
    a_select_gap: assert property ($rose(select_n_out) |=> select_n_out)
        else $error("Select low again without recovery.");
    c_read: cover property (rd);
    c_write: cover property (wr);
    c_pulse: cover property (rd_valid_out);
endmodule

/* tb/sctl_mem_model.sv */
`timescale 1ns/1ps
module sctl_mem_model
    import sctl_pkg::*;
#(
    parameter int ACCESS_NS = 80  // Read access delay, inside the limit.
) (
    input  wire logic               select_n_in,   // Device select, active low.
    input  wire logic               strobe_n_in,   // Write strobe, active low.
    input  wire logic               drive_n_in,    // Output drive, active low.
    input  wire logic [INDEX_W-1:0] word_index_in, // Word index.
    input  wire logic [DATA_W-1:0]  data_lines_in, // Resolved data wire.
    output logic [DATA_W-1:0]       mem_data_out,  // Data the memory drives.
    output logic                    mem_oe_out     // High while the memory drives.
);
    // ==========================================================
    // Storage
    // ==========================================================
    logic [DATA_W-1:0] cells [WORDS];
    wire               writing = !select_n_in && !strobe_n_in;

    // The wire level at the end of the overlap is stored; deselect alone keeps cells.
    always @(negedge writing) cells[word_index_in] <= data_lines_in;

    // Turn-on lags select and data lags the index, so an early sample sees the float pattern or stale data, as a real part would.
    assign #15 mem_oe_out = !select_n_in
                         && strobe_n_in
                         && !drive_n_in;
    assign #(ACCESS_NS) mem_data_out = cells[word_index_in];
endmodule
